// File: shared/txf_pkg.sv
package txf_pkg;

  // register byte offsets on the host port
  localparam logic [7:0] OFS_DATA_PORT  = 8'h00;
  localparam logic [7:0] OFS_STAT_PORT  = 8'h04;
  localparam logic [7:0] OFS_STAT_PEEK  = 8'h08;
  localparam logic [7:0] OFS_CONFIG     = 8'h0C;
  localparam logic [7:0] OFS_SPACE_INFO = 8'h10;
  localparam logic [7:0] OFS_FLAGS      = 8'h14;

  // config register fields
  localparam int CFG_OVR_ALLOW_BIT = 0;
  localparam int CFG_SF_BIT        = 1;
  localparam int CFG_DEFER_CHK_BIT = 2;
  localparam int CFG_FLUSH_BIT     = 3;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // flags register fields, write one to clear
  localparam int FLG_TXE_BIT      = 0;
  localparam int FLG_UNDERRUN_BIT = 1;

  // default depths in 32-bit words
  localparam int DATA_DEPTH_DEF = 512;
  localparam int STAT_DEPTH_DEF = 16;

  // buffer end alignment codes and their byte masks
  localparam logic [1:0]  ALIGN_4   = 2'h0;
  localparam logic [1:0]  ALIGN_16  = 2'h1;
  localparam logic [1:0]  ALIGN_32  = 2'h2;
  localparam logic [11:0] MASK_4    = 12'h003;
  localparam logic [11:0] MASK_16   = 12'h00F;
  localparam logic [11:0] MASK_32   = 12'h01F;

  typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_DATA} txf_parse_t;

  typedef struct packed {
    logic [5:0]  rsvd_hi;
    logic [1:0]  end_align;
    logic [2:0]  rsvd_mid;
    logic [4:0]  start_offset;
    logic [1:0]  rsvd_lo;
    logic        first_segment;
    logic        last_segment;
    logic        rsvd_b11;
    logic [10:0] buf_size;
  } txf_cmd_a_t;

  typedef struct packed {
    logic [15:0] tag;
    logic [4:0]  ctl;
    logic [10:0] pkt_len;
  } txf_cmd_b_t;

  typedef struct packed {
    logic [15:0] tag;
    logic        error_summary;
    logic [2:0]  rsvd_hi;
    logic        loss_carrier;
    logic        no_carrier;
    logic        late_collision;
    logic        excess_collision;
    logic        rsvd_b7;
    logic [3:0]  collision_count;
    logic        excess_deferral;
    logic        underrun;
    logic        deferred;
  } txf_status_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } txf_bus_t;

endpackage

// File: src/txf_fifo.sv
`timescale 1ns/10ps
module txf_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          arst_n,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          pop,
  output logic      [W-1:0]  rdata,
  output logic               full,
  output logic               empty,
  output logic      [CW-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;

  wire do_pop  = pop && !empty;
  wire do_push = push && (!full || do_pop);

  assign rdata = mem_reg[rd_ptr_reg];
  assign full  = (count_reg == CW'(DEPTH));
  assign empty = (count_reg == '0);
  assign count = count_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (ce) begin
      if (flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (do_push) begin
          mem_reg[wr_ptr_reg] <= wdata;
          wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (do_pop) begin
          rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
        end
        count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
    end
  end
endmodule // txf_fifo

// File: src/txf_tx_buffer.sv
`timescale 1ns/10ps
module txf_tx_buffer
  import txf_pkg::*;
#(
  parameter int DATA_DEPTH = txf_pkg::DATA_DEPTH_DEF,
  parameter int STAT_DEPTH = txf_pkg::STAT_DEPTH_DEF
) (
  input  wire logic               clk,
  input  wire logic               ce,
  input  wire logic               arst_n,
  input  wire txf_pkg::txf_bus_t  bus,
  output logic [31:0]             rdata,
  output logic                    mac_valid,
  output logic [31:0]             mac_data,
  input  wire logic               mac_ready,
  output logic                    mac_suspend,
  input  wire logic               mac_underrun,
  input  wire logic               mac_stat_valid,
  input  wire txf_pkg::txf_status_t mac_stat
);
  import txf_pkg::*;

  localparam int DCW = $clog2(DATA_DEPTH + 1);
  localparam int SCW = $clog2(STAT_DEPTH + 1);

  // host register decode
  wire wr_data_port = bus.wr && (bus.addr == OFS_DATA_PORT);
  wire wr_config    = bus.wr && (bus.addr == OFS_CONFIG);
  wire wr_flags     = bus.wr && (bus.addr == OFS_FLAGS);
  wire rd_stat_port = bus.rd && (bus.addr == OFS_STAT_PORT);

  logic [2:0]  cfg_reg;
  logic        txe_reg;
  logic        underrun_flag_reg;
  logic        underrun_hold_reg;
  logic        stat_lock_reg;
  logic [31:0] rdata_reg;

  wire ovr_allow     = cfg_reg[CFG_OVR_ALLOW_BIT];
  wire store_forward = cfg_reg[CFG_SF_BIT];
  wire defer_chk     = cfg_reg[CFG_DEFER_CHK_BIT];
  wire flush_data    = wr_config && bus.wdata[CFG_FLUSH_BIT];

  // buffer parser
  txf_parse_t  state_reg;
  txf_parse_t  state_next;
  txf_cmd_a_t  cmd_a_reg;
  txf_cmd_a_t  cmd_a_next;
  txf_cmd_b_t  pkt_b_reg;
  txf_cmd_b_t  pkt_b_next;
  logic [11:0] len_acc_reg;
  logic [11:0] len_acc_next;
  logic [9:0]  widx_reg;
  logic [9:0]  widx_next;
  logic        push_req;
  logic        len_err;
  logic        b_err;
  logic        buf_done;

  wire txf_cmd_b_t cmd_b_in = txf_cmd_b_t'(bus.wdata);

  // byte geometry of the buffer being written
  wire [11:0] align_mask = (cmd_a_reg.end_align == ALIGN_32) ? MASK_32 :
                           (cmd_a_reg.end_align == ALIGN_16) ? MASK_16 : MASK_4;
  wire [11:0] buf_end    = {7'h00, cmd_a_reg.start_offset} + {1'b0, cmd_a_reg.buf_size};
  wire [11:0] buf_round  = (buf_end + align_mask) & ~align_mask;
  wire [9:0]  words_tot  = buf_round[11:2];
  wire [11:0] last_byte  = buf_end - 12'h001;
  wire [9:0]  keep_first = {7'h00, cmd_a_reg.start_offset[4:2]};
  wire [9:0]  keep_last  = last_byte[11:2];
  // whole dwords of offset and padding fall outside this window
  wire        keep_word  = (cmd_a_reg.buf_size != 11'h000) &&
                           (widx_reg >= keep_first) && (widx_reg <= keep_last);

  always_comb begin
    state_next   = state_reg;
    cmd_a_next   = cmd_a_reg;
    pkt_b_next   = pkt_b_reg;
    len_acc_next = len_acc_reg;
    widx_next    = widx_reg;
    push_req     = 1'b0;
    b_err        = 1'b0;
    buf_done     = 1'b0;
    if (wr_data_port) begin
      unique case (state_reg)
        ST_CMD_A: begin
          cmd_a_next = txf_cmd_a_t'(bus.wdata);
          push_req   = 1'b1;
          state_next = ST_CMD_B;
        end
        ST_CMD_B: begin
          widx_next = '0;
          if (cmd_a_reg.first_segment) begin
            pkt_b_next   = cmd_b_in;
            push_req     = 1'b1;
            len_acc_next = {1'b0, cmd_a_reg.buf_size};
          end else begin
            b_err        = (cmd_b_in != pkt_b_reg);
            len_acc_next = len_acc_reg + {1'b0, cmd_a_reg.buf_size};
          end
          if (words_tot == '0) begin
            state_next = ST_CMD_A;
            buf_done   = 1'b1;
          end else begin
            state_next = ST_DATA;
          end
        end
        ST_DATA: begin
          push_req  = keep_word;
          widx_next = widx_reg + 10'h001;
          if (widx_reg == words_tot - 10'h001) begin
            state_next = ST_CMD_A;
            buf_done   = 1'b1;
          end
        end
        default: begin
          state_next = ST_CMD_A;
        end
      endcase
    end
  end

  // packet length is checked when its last segment ends
  assign len_err = buf_done && cmd_a_reg.last_segment &&
                   (len_acc_next != {1'b0, pkt_b_next.pkt_len});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= ST_CMD_A;
      cmd_a_reg   <= '0;
      pkt_b_reg   <= '0;
      len_acc_reg <= '0;
      widx_reg    <= '0;
    end else if (ce) begin
      state_reg   <= state_next;
      cmd_a_reg   <= cmd_a_next;
      pkt_b_reg   <= pkt_b_next;
      len_acc_reg <= len_acc_next;
      widx_reg    <= widx_next;
    end
  end

  // data fifo, mac side
  logic [31:0]    data_head;
  logic           data_full;
  logic           data_empty;
  logic [DCW-1:0] data_count;

  // a full fifo drops the host word; the parser still advances to stay aligned
  wire host_overrun = push_req && data_full;
  wire stat_full_w;
  // data stalls while the status fifo is full and overrun is not allowed, and after an underrun outside store-and-forward until flush
  assign mac_suspend = stat_full_w && !ovr_allow;
  assign mac_valid   = !data_empty && !mac_suspend && !underrun_hold_reg;
  assign mac_data    = data_head;
  wire data_pop      = mac_valid && mac_ready;

  txf_fifo #(
    .W     (32),
    .DEPTH (DATA_DEPTH),
    .CW    (DCW)
  ) u_data_fifo (
    .clk    (clk),
    .ce     (ce),
    .arst_n (arst_n),
    .flush  (flush_data),
    .push   (push_req && !data_full),
    .wdata  (bus.wdata),
    .pop    (data_pop),
    .rdata  (data_head),
    .full   (data_full),
    .empty  (data_empty),
    .count  (data_count)
  );

  // status word assembly
  txf_status_t stat_word;
  always_comb begin
    stat_word                  = '0;
    stat_word.tag              = mac_stat.tag;
    stat_word.loss_carrier     = mac_stat.loss_carrier;
    stat_word.no_carrier       = mac_stat.no_carrier;
    stat_word.late_collision   = mac_stat.late_collision;
    stat_word.excess_collision = mac_stat.excess_collision;
    stat_word.collision_count  = mac_stat.collision_count;
    stat_word.excess_deferral  = mac_stat.excess_deferral && defer_chk;
    stat_word.underrun         = mac_stat.underrun;
    stat_word.deferred         = mac_stat.deferred;
    stat_word.error_summary    = stat_word.loss_carrier | stat_word.no_carrier |
                                 stat_word.late_collision | stat_word.excess_collision |
                                 stat_word.excess_deferral | stat_word.underrun;
  end

  // status fifo
  logic [31:0]    stat_head;
  logic           stat_empty;
  logic [SCW-1:0] stat_count;

  wire stat_pop  = rd_stat_port && !stat_empty;
  // one word per packet unless locked out or no room
  wire stat_push = mac_stat_valid && !stat_lock_reg && !stat_full_w;
  wire stat_ovf  = mac_stat_valid && !stat_lock_reg && stat_full_w;
  wire lock_set  = stat_ovf && ovr_allow;
  wire stat_err  = stat_ovf && !ovr_allow;

  txf_fifo #(
    .W     (32),
    .DEPTH (STAT_DEPTH),
    .CW    (SCW)
  ) u_stat_fifo (
    .clk    (clk),
    .ce     (ce),
    .arst_n (arst_n),
    .flush  (1'b0),
    .push   (stat_push),
    .wdata  (stat_word),
    .pop    (stat_pop),
    .rdata  (stat_head),
    .full   (stat_full_w),
    .empty  (stat_empty),
    .count  (stat_count)
  );

  // sticky flags and config
  // underrun only counts outside store-and-forward
  wire underrun_evt = mac_underrun && !store_forward;
  wire txe_set      = len_err || b_err || host_overrun || stat_err ||
                      (mac_stat_valid && mac_stat.underrun);
  wire txe_clr      = wr_flags && bus.wdata[FLG_TXE_BIT];
  wire undf_clr     = wr_flags && bus.wdata[FLG_UNDERRUN_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg           <= CFG_RESET;
      txe_reg           <= 1'b0;
      underrun_flag_reg <= 1'b0;
      underrun_hold_reg <= 1'b0;
      stat_lock_reg     <= 1'b0;
    end else if (ce) begin
      if (wr_config) begin
        cfg_reg <= bus.wdata[2:0];
      end
      // set beats clear so a same-cycle event is not lost
      txe_reg           <= txe_set || (txe_reg && !txe_clr);
      underrun_flag_reg <= underrun_evt || (underrun_flag_reg && !undf_clr);
      underrun_hold_reg <= underrun_evt || (underrun_hold_reg && !flush_data);
      // a host status read frees room and ends the lockout
      stat_lock_reg     <= lock_set || (stat_lock_reg && !stat_pop);
    end
  end

  // read path, data one cycle after the strobe
  // used count reads zero during a lockout, as software expects
  wire [7:0]  stat_used  = stat_lock_reg ? 8'h00 : 8'(stat_count);
  wire [15:0] free_words = 16'(DATA_DEPTH) - 16'(data_count);
  // leftover frame data stays counted until the flush
  wire [15:0] free_bytes = {free_words[13:0], 2'b00};
  wire [31:0] rd_mux     = (bus.addr == OFS_STAT_PORT)  ? stat_head :
                           (bus.addr == OFS_STAT_PEEK)  ? stat_head :
                           (bus.addr == OFS_CONFIG)     ? {29'h0, cfg_reg} :
                           (bus.addr == OFS_SPACE_INFO) ? {8'h00, stat_used, free_bytes} :
                           (bus.addr == OFS_FLAGS)      ? {30'h0, underrun_flag_reg, txe_reg} :
                                                          32'h0000_0000;
  wire        stat_hide  = ((bus.addr == OFS_STAT_PORT) || (bus.addr == OFS_STAT_PEEK)) && stat_empty;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= (bus.rd && !stat_hide) ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;
endmodule // txf_tx_buffer

// File: test/txf_tx_buffer_assertions.sv
`timescale 1ns/10ps
module txf_chk #(
  parameter int DATA_DEPTH = 8,
  parameter int STAT_DEPTH = 4
) (
  input wire logic                 clk,
  input wire logic                 ce,
  input wire logic                 arst_n,
  input wire txf_pkg::txf_bus_t    bus,
  input wire logic [31:0]          rdata,
  input wire logic                 mac_valid,
  input wire logic [31:0]          mac_data,
  input wire logic                 mac_ready,
  input wire logic                 mac_suspend,
  input wire logic                 mac_underrun,
  input wire logic                 mac_stat_valid,
  input wire txf_pkg::txf_status_t mac_stat
);
  import txf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic sf_q;
  logic hold_q;
  wire cfg_wr = ce && bus.wr && bus.addr == OFS_CONFIG;
  wire flush  = cfg_wr && bus.wdata[CFG_FLUSH_BIT];
  wire pop_rd = ce && bus.rd && bus.addr == OFS_STAT_PORT;
  wire st_rd  = pop_rd || (ce && bus.rd && bus.addr == OFS_STAT_PEEK);
  wire sp_rd  = ce && bus.rd && bus.addr == OFS_SPACE_INFO;
  // config is write-only from here, so the hold is rebuilt from bus traffic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sf_q   <= 1'b0;
      hold_q <= 1'b0;
    end else if (ce) begin
      if (cfg_wr) sf_q <= bus.wdata[CFG_SF_BIT];
      if (flush) hold_q <= 1'b0;
      else if (mac_underrun && !sf_q) hold_q <= 1'b1;
    end
  end
  chk_suspend_gate: assert property (mac_suspend |-> !mac_valid)
    else $error("data offered while suspended");
  chk_suspend_cause: assert property ($rose(mac_suspend) |-> $past(mac_stat_valid) || $past(cfg_wr))
    else $error("suspend without status push");
  chk_suspend_release: assert property (mac_suspend && pop_rd && !mac_stat_valid |=> !mac_suspend)
    else $error("suspend held after status pop");
  chk_underrun_hold: assert property (hold_q |-> !mac_valid)
    else $error("frame data after underrun");
  chk_flush_empty: assert property (flush |=> !mac_valid)
    else $error("data left after flush");
  chk_error_sum: assert property (st_rd |=> rdata[15] == |{rdata[11:8], rdata[2:1]}
    && rdata[14:12] == 3'h0 && !rdata[7]) else $error("bad summary or reserved bits");
  chk_space_free: assert property (sp_rd |=> rdata[1:0] == 2'h0 && rdata[15:0] <= 16'(DATA_DEPTH * 4))
    else $error("free space out of range");
  chk_used_range: assert property (sp_rd |=> rdata[23:16] <= 8'(STAT_DEPTH))
    else $error("used count out of range");
  chk_head_stable: assert property (ce && mac_valid && !mac_ready && !flush |=> $stable(mac_data))
    else $error("head moved without pop");
  cover property (mac_suspend && pop_rd);
  cover property (hold_q && flush);
  cover property (st_rd ##1 rdata[15]);
endmodule // txf_chk

bind txf_tx_buffer txf_chk #(.DATA_DEPTH(DATA_DEPTH), .STAT_DEPTH(STAT_DEPTH)) u_txf_chk (.clk(clk), .ce(ce),
  .arst_n(arst_n), .bus(bus), .rdata(rdata), .mac_valid(mac_valid), .mac_data(mac_data), .mac_ready(mac_ready),
  .mac_suspend(mac_suspend), .mac_underrun(mac_underrun), .mac_stat_valid(mac_stat_valid), .mac_stat(mac_stat));

// File: test/txf_mac_model.sv
`timescale 1ns/10ps
module txf_mac_model (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            mac_valid,
  input  wire logic [31:0]     mac_data,
  output logic                 mac_ready,
  output logic                 mac_underrun,
  output logic                 mac_stat_valid,
  output txf_pkg::txf_status_t mac_stat
);
  import txf_pkg::*;
  logic [31:0] got[$];
  int          stall = 25;
  int          seed = 63797;
  initial begin
    mac_ready = 1'b0;
    mac_underrun = 1'b0;
    mac_stat_valid = 1'b0;
    mac_stat = '0;
  end
  // ready drawn each cycle: prompt and slow pulls mixed, 100 stops the line
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_ready <= 1'b0;
    end else begin
      if (mac_valid && mac_ready) got.push_back(mac_data);
      mac_ready <= ({$random(seed)} % 100) >= stall;
    end
  end
  task automatic send_stat(input txf_status_t s);
    @(posedge clk);
    mac_stat <= s;
    mac_stat_valid <= 1'b1;
    @(posedge clk);
    mac_stat_valid <= 1'b0;
    mac_stat <= ~s;
  endtask
  task automatic pulse_underrun;
    @(posedge clk);
    mac_underrun <= 1'b1;
    @(posedge clk);
    mac_underrun <= 1'b0;
  endtask
endmodule // txf_mac_model

// File: test/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  import txf_pkg::*;
  localparam int DD = 8;
  localparam int SD = 4;
  logic        clk = 1'b0;
  logic        ce = 1'b1;
  logic        arst_n = 1'b0;
  txf_bus_t    bus = '0;
  logic [31:0] rdata;
  logic [31:0] mac_data;
  logic [31:0] rv;
  logic        mac_valid;
  logic        mac_ready;
  logic        mac_suspend;
  logic        mac_underrun;
  logic        mac_stat_valid;
  txf_status_t mac_stat;
  logic [31:0] exp_q[$];
  int          seed = 63797;
  int          mismatches = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  txf_tx_buffer #(.DATA_DEPTH(DD), .STAT_DEPTH(SD)) u_txf_tx_buffer (.clk(clk), .ce(ce), .arst_n(arst_n),
    .bus(bus), .rdata(rdata), .mac_valid(mac_valid), .mac_data(mac_data), .mac_ready(mac_ready),
    .mac_suspend(mac_suspend), .mac_underrun(mac_underrun), .mac_stat_valid(mac_stat_valid), .mac_stat(mac_stat));
  txf_mac_model u_txf_mac_model (.clk(clk), .arst_n(arst_n), .mac_valid(mac_valid), .mac_data(mac_data),
    .mac_ready(mac_ready), .mac_underrun(mac_underrun), .mac_stat_valid(mac_stat_valid), .mac_stat(mac_stat));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one strobe cycle, then an idle cycle with scrambled address and data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '{addr: 8'($random(seed)), wdata: $random(seed), wr: 1'b0, rd: 1'b0};
    #1 rv = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(n, e, rv)
  endtask
  task automatic send_buf(input logic [4:0] o, input logic [10:0] z, input logic [1:0] a, input logic fs,
                          input logic ls, input logic [31:0] cb);
    int          ab;
    int          tot;
    logic [31:0] d;
    logic [31:0] ca;
    ab = (a == ALIGN_32) ? 32 : (a == ALIGN_16) ? 16 : 4;
    tot = (o + z + ab - 1) / ab * ab / 4;
    ca = {6'h0, a, 3'h0, o, 2'h0, fs, ls, 1'b0, z};
    acc(1'b1, OFS_DATA_PORT, ca);
    acc(1'b1, OFS_DATA_PORT, cb);
    exp_q.push_back(ca);
    if (fs) exp_q.push_back(cb);
    for (int i = 0; i < tot; i++) begin
      d = $random(seed);
      acc(1'b1, OFS_DATA_PORT, d);
      if (i >= o / 4 && i <= (o + z - 1) / 4) exp_q.push_back(d);
    end
  endtask
  task automatic drain_chk;
    int n;
    n = 0;
    while (u_txf_mac_model.got.size() < exp_q.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    `CHK("words", exp_q.size(), u_txf_mac_model.got.size())
    foreach (exp_q[i]) `CHK("word", exp_q[i], u_txf_mac_model.got[i])
    exp_q = {};
    u_txf_mac_model.got = {};
  endtask
  function automatic logic [31:0] exp_st(input txf_status_t s, input logic dchk);
    txf_status_t e;
    e = s;
    e.excess_deferral = s.excess_deferral & dchk;
    e.rsvd_hi = 3'h0;
    e.rsvd_b7 = 1'b0;
    e.error_summary = |{e.loss_carrier, e.no_carrier, e.late_collision, e.excess_collision, e.excess_deferral,
                        e.underrun};
    return e;
  endfunction
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial begin
    txf_status_t s;
    logic [31:0] sq[$];
    logic [10:0] z;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("cfg", OFS_CONFIG, {29'h0, CFG_RESET});
    rchk("space", OFS_SPACE_INFO, DD * 4);
    rchk("unmapped", 8'h18, 32'h0);
    // high byte start, low byte end: the two byte worst case
    send_buf(5'd3, 11'd2, ALIGN_4, 1'b1, 1'b1, 32'h00A5_0002);
    send_buf(5'd31, 11'd1, ALIGN_32, 1'b1, 1'b1, 32'h0001_0001);
    repeat (6) begin
      z = 11'({$random(seed)} % 64 + 1);
      send_buf(5'($random(seed)), z, 2'({$random(seed)} % 3), 1'b1, 1'b1, {16'($random(seed)), 5'h0, z});
    end
    drain_chk();
    rchk("flags", OFS_FLAGS, 32'h0);
    send_buf(5'd0, 11'd4, ALIGN_4, 1'b1, 1'b0, 32'h1111_0008);
    send_buf(5'd0, 11'd4, ALIGN_4, 1'b0, 1'b1, 32'h2222_0008);
    drain_chk();
    rchk("flags", OFS_FLAGS, 32'h1);
    rchk("flags", OFS_FLAGS, 32'h1);
    acc(1'b1, OFS_FLAGS, 32'h3);
    send_buf(5'd0, 11'd4, ALIGN_4, 1'b1, 1'b1, 32'h3333_0005);
    drain_chk();
    rchk("flags", OFS_FLAGS, 32'h1);
    acc(1'b1, OFS_FLAGS, 32'h3);
    u_txf_mac_model.stall = 100;
    repeat (2) @(posedge clk);
    send_buf(5'd0, 11'd40, ALIGN_4, 1'b1, 1'b1, 32'h4444_0028);
    rchk("space", OFS_SPACE_INFO, 32'h0);
    rchk("flags", OFS_FLAGS, 32'h1);
    acc(1'b1, OFS_CONFIG, 32'h8);
    rchk("space", OFS_SPACE_INFO, DD * 4);
    acc(1'b1, OFS_FLAGS, 32'h3);
    exp_q = {};
    send_buf(5'd0, 11'd8, ALIGN_4, 1'b1, 1'b1, 32'h5555_0008);
    u_txf_mac_model.pulse_underrun();
    rchk("flags", OFS_FLAGS, 32'h2);
    rchk("space", OFS_SPACE_INFO, (DD - 4) * 4);
    acc(1'b1, OFS_CONFIG, 32'h8);
    rchk("space", OFS_SPACE_INFO, DD * 4);
    exp_q = {};
    acc(1'b1, OFS_FLAGS, 32'h3);
    u_txf_mac_model.stall = 25;
    send_buf(5'd2, 11'd9, ALIGN_16, 1'b1, 1'b1, 32'h6666_0009);
    drain_chk();
    acc(1'b1, OFS_CONFIG, 32'h2);
    u_txf_mac_model.pulse_underrun();
    rchk("flags", OFS_FLAGS, 32'h0);
    acc(1'b1, OFS_CONFIG, 32'h4);
    repeat (SD) begin
      s = $random(seed);
      s.underrun = 1'b0;
      sq.push_back(exp_st(s, 1'b1));
      u_txf_mac_model.send_stat(s);
    end
    #1 `CHK("suspend", 1'b1, mac_suspend)
    rchk("used", OFS_SPACE_INFO, {8'h0, 8'(SD), 16'(DD * 4)});
    u_txf_mac_model.send_stat(s);
    rchk("flags", OFS_FLAGS, 32'h1);
    rchk("peek", OFS_STAT_PEEK, sq[0]);
    foreach (sq[i]) rchk("stat", OFS_STAT_PORT, sq[i]);
    rchk("peek", OFS_STAT_PEEK, 32'h0);
    sq = {};
    acc(1'b1, OFS_FLAGS, 32'h3);
    acc(1'b1, OFS_CONFIG, 32'h1);
    repeat (SD + 1) begin
      s = $random(seed);
      s.underrun = 1'b0;
      sq.push_back(exp_st(s, 1'b0));
      u_txf_mac_model.send_stat(s);
    end
    #1 `CHK("suspend", 1'b0, mac_suspend)
    rchk("used", OFS_SPACE_INFO, DD * 4);
    rchk("flags", OFS_FLAGS, 32'h0);
    rchk("stat", OFS_STAT_PORT, sq[0]);
    rchk("used", OFS_SPACE_INFO, {8'h0, 8'(SD - 1), 16'(DD * 4)});
    for (int i = 1; i < SD; i++) rchk("stat", OFS_STAT_PORT, sq[i]);
    s = '0;
    s.underrun = 1'b1;
    s.tag = 16'hBEEF;
    u_txf_mac_model.send_stat(s);
    rchk("flags", OFS_FLAGS, 32'h1);
    rchk("stat", OFS_STAT_PORT, 32'hBEEF_8002);
    stop_test();
  end
endmodule // tb_top
